// ### hw/nclea_pkg.sv
// nclea_pkg: constants and types for the nibble load/exchange/arith unit
// assumes a byte-wide program store read combinationally and a 32-bit APB
package nclea_pkg;

  // data path widths
  localparam int ACC_W = 4;                  // accumulator and ram nibble
  localparam int COL_W = 4;                  // pointer column part
  localparam int ROW_W = 3;                  // pointer row part
  localparam int PC_W = 11;                  // program address width
  localparam int ROWS = 8;                   // ram rows of sixteen columns
  localparam int COLS = 16;                  // columns per ram row

  // opcodes and opcode patterns
  localparam logic [7:0] OP_LOAD_MEM = 8'h38;      // ram to accumulator
  localparam logic [7:0] OP_STORE = 8'h02;         // accumulator to ram
  localparam logic [7:0] OP_WORK_TO_COL = 8'h07;   // work_to_column_copy
  localparam logic [7:0] OP_COL_TO_WORK = 8'h12;   // column_to_work_copy
  localparam logic [7:0] OP_SWAP = 8'h28;          // plain exchange
  localparam logic [7:0] OP_SWAP_UP = 8'h3C;       // swap_then_step_up
  localparam logic [7:0] OP_SWAP_DOWN = 8'h2C;     // swap_then_step_down
  localparam logic [7:0] OP_SUM = 8'h08;           // add, skip on overflow
  localparam logic [7:0] OP_SUM_CARRY = 8'h19;     // add with carry
  localparam logic [7:0] OP_SUM_CARRY_SKIP = 8'h09; // sum_carry_then_skip
  localparam logic [7:0] OP_BCD_SUM = 8'h06;       // bcd_fix_after_sum
  localparam logic [7:0] OP_BCD_DIFF = 8'h0A;      // bcd_fix_after_difference
  localparam logic [7:0] OP_FULL_PTR = 8'h15;      // full_pointer_set, first byte
  localparam logic [3:0] HI_LOAD_IMM = 4'h9;       // load_immediate_nibble high nibble
  localparam logic [3:0] HI_ZERO_ROW = 4'h8;       // zero_row_pointer_set high nibble
  localparam logic [5:0] PAT_MEM_TOGGLE = 6'h0E;   // 001110dd
  localparam logic [5:0] PAT_SWAP_TOGGLE = 6'h0A;  // 001010dd
  localparam logic [5:0] PAT_TOGGLE_UP = 6'h0F;    // 001111dd
  localparam logic [5:0] PAT_TOGGLE_DOWN = 6'h0B;  // 001011dd

  // decimal adjust constants
  localparam logic [3:0] BCD_SUM_ADD = 4'h6;
  localparam logic [3:0] BCD_DIFF_ADD = 4'hA;

  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;   // bit0 run
  localparam logic [7:0] OFS_STATE = 8'h04;  // core state readback
  localparam logic [7:0] OFS_PC = 8'h08;     // program address readback
  localparam int CTRL_RUN_BIT = 0;
  localparam int ST_ACC_LSB = 0;
  localparam int ST_COL_LSB = 4;
  localparam int ST_ROW_LSB = 8;
  localparam int ST_CARRY_BIT = 12;
  localparam int ST_SKIP_BIT = 13;
  localparam int ST_CHAIN_BIT = 14;
  localparam logic CTRL_RUN_RST = 1'b0;

  // ram pointer: row part above column part
  typedef struct packed {
    logic [ROW_W-1:0] row;  // pointer_row_part
    logic [COL_W-1:0] col;  // pointer_column_part
  } nclea_ptr_t;

  // sequencer states
  typedef enum logic [1:0] {ST_FETCH, ST_OPERAND, ST_SKIP_OPERAND} nclea_state_t;

endpackage

// ### hw/nclea_core.sv
// nclea_core: decode and execute of the load, store, transfer, exchange and add group
// assumes program bytes arrive combinationally for rom_addr, one instruction cycle per pclk
// Operation
// - load_immediate_nibble loads accumulator; string repeats skip
// - memory load copies addressed nibble to accumulator
// - memory_copy_row_toggle loads, XORs row with operand
// - full_pointer_set: two bytes, seven-bit pointer load
// - zero_row_pointer_set clears row, loads column
// - store writes accumulator to addressed nibble
// - plain exchange swaps accumulator and nibble
// - swap_then_step_up increments column, skip on zero
// - swap_then_step_down decrements column, skip on ones
// - swap_row_toggle swaps, XORs row, no skip
// - swap_toggle_step_up swaps, toggles row, increments, skips
// - swap_toggle_step_down swaps, toggles row, decrements, skips
// - plain add keeps sum, skips on overflow
// - add with carry sets carry, never skips
// - sum_carry_then_skip sets carry and skips
// - bcd_fix_after_sum adds six
// - bcd_fix_after_difference adds ten
// - skip discards whole next instruction, its bytes
// - pointer is column low, row high
// - ram is rows of sixteen columns
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/100ps
module nclea_core
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [nclea_pkg::PC_W-1:0] rom_addr,
  input wire logic [7:0] rom_data
);

  // architectural state
  logic [nclea_pkg::ACC_W-1:0] acc_r;              // accumulator
  logic [nclea_pkg::ACC_W-1:0] acc_nxt;
  nclea_pkg::nclea_ptr_t ptr_r;                     // ram_pointer
  nclea_pkg::nclea_ptr_t ptr_nxt;
  logic carry_r;                                    // carry flag
  logic carry_nxt;
  logic skip_r;                                     // next instruction is discarded
  logic skip_nxt;
  logic chain_r;                                    // last executed was immediate load
  logic chain_nxt;
  logic [nclea_pkg::PC_W-1:0] pc_r;                 // program address
  logic [nclea_pkg::PC_W-1:0] pc_nxt;
  nclea_pkg::nclea_state_t state_r;                 // sequencer state
  nclea_pkg::nclea_state_t state_nxt;
  logic run_r;                                      // software run enable
  logic [31:0] prdata_r;                            // registered read data

  // data ram and write port
  logic [nclea_pkg::ACC_W-1:0] ram_mem [nclea_pkg::ROWS][nclea_pkg::COLS];
  logic ram_we;                                     // write this cycle
  logic [nclea_pkg::ACC_W-1:0] ram_wdata;           // nibble to write
  logic [nclea_pkg::ACC_W-1:0] ram_rdata;           // addressed nibble

  // adder helpers
  logic [nclea_pkg::ACC_W:0] sum_plain;             // acc + ram
  logic [nclea_pkg::ACC_W:0] sum_carry;             // acc + ram + carry
  logic [nclea_pkg::ACC_W-1:0] col_up;              // column plus one
  logic [nclea_pkg::ACC_W-1:0] col_down;            // column minus one
  logic [nclea_pkg::ROW_W-1:0] row_toggled;         // row xor operand
  logic [1:0] operand2;                             // two-bit immediate
  logic [5:0] op_hi6;                               // top six opcode bits

  // apb decode
  logic apb_wr;                                     // write access phase
  logic apb_rd;                                     // read transfer, setup or access phase
  logic addr_hit;                                   // mapped offset

  // ram read: row selects row, column selects column
  assign ram_rdata = ram_mem[ptr_r.row][ptr_r.col];

  // shared arithmetic, carry out of bit three is overflow
  assign sum_plain = {1'b0, acc_r} + {1'b0, ram_rdata};
  assign sum_carry = {1'b0, acc_r} + {1'b0, ram_rdata} + {4'h0, carry_r};
  assign col_up = ptr_r.col + 4'h1;
  assign col_down = ptr_r.col - 4'h1;
  assign operand2 = rom_data[1:0];
  assign row_toggled = ptr_r.row ^ {1'b0, operand2};
  assign op_hi6 = rom_data[7:2];

  // program address goes straight to the store
  assign rom_addr = pc_r;

  // decode and execute for one fetched byte
  always_comb
  begin
    acc_nxt = acc_r;
    ptr_nxt = ptr_r;
    carry_nxt = carry_r;
    skip_nxt = skip_r;
    chain_nxt = chain_r;
    pc_nxt = pc_r;
    state_nxt = state_r;
    ram_we = 1'b0;
    ram_wdata = acc_r;
    if (run_r)
    begin
      unique case (state_r)
        nclea_pkg::ST_FETCH:
        begin
          pc_nxt = pc_r + 11'h001;
          if (skip_r)
          begin
            // discarded instruction, its full length consumed
            skip_nxt = 1'b0;
            chain_nxt = 1'b0;
            if (rom_data == nclea_pkg::OP_FULL_PTR)
            begin
              state_nxt = nclea_pkg::ST_SKIP_OPERAND;
            end
          end
          else
          begin
            chain_nxt = 1'b0;
            if (rom_data[7:4] == nclea_pkg::HI_LOAD_IMM)
            begin
              // first of a string loads, the rest do nothing
              chain_nxt = 1'b1;
              if (!chain_r)
              begin
                acc_nxt = rom_data[3:0];
              end
            end
            else if (rom_data[7:4] == nclea_pkg::HI_ZERO_ROW)
            begin
              // row cleared, column from operand
              ptr_nxt.row = '0;
              ptr_nxt.col = rom_data[3:0];
            end
            else if (rom_data == nclea_pkg::OP_FULL_PTR)
            begin
              // second byte carries the pointer
              state_nxt = nclea_pkg::ST_OPERAND;
            end
            else if (rom_data == nclea_pkg::OP_LOAD_MEM)
            begin
              acc_nxt = ram_rdata;
            end
            else if (rom_data == nclea_pkg::OP_STORE)
            begin
              ram_we = 1'b1;
            end
            else if (rom_data == nclea_pkg::OP_WORK_TO_COL)
            begin
              ptr_nxt.col = acc_r;
            end
            else if (rom_data == nclea_pkg::OP_COL_TO_WORK)
            begin
              acc_nxt = ptr_r.col;
            end
            else if (rom_data == nclea_pkg::OP_SWAP)
            begin
              // pointer left alone
              acc_nxt = ram_rdata;
              ram_we = 1'b1;
            end
            else if (rom_data == nclea_pkg::OP_SWAP_UP)
            begin
              acc_nxt = ram_rdata;
              ram_we = 1'b1;
              ptr_nxt.col = col_up;
              skip_nxt = (col_up == 4'h0);
            end
            else if (rom_data == nclea_pkg::OP_SWAP_DOWN)
            begin
              acc_nxt = ram_rdata;
              ram_we = 1'b1;
              ptr_nxt.col = col_down;
              skip_nxt = (col_down == 4'hF);
            end
            else if (op_hi6 == nclea_pkg::PAT_MEM_TOGGLE)
            begin
              acc_nxt = ram_rdata;
              ptr_nxt.row = row_toggled;
            end
            else if (op_hi6 == nclea_pkg::PAT_SWAP_TOGGLE)
            begin
              // never skips
              acc_nxt = ram_rdata;
              ram_we = 1'b1;
              ptr_nxt.row = row_toggled;
            end
            else if (op_hi6 == nclea_pkg::PAT_TOGGLE_UP)
            begin
              acc_nxt = ram_rdata;
              ram_we = 1'b1;
              ptr_nxt.row = row_toggled;
              ptr_nxt.col = col_up;
              skip_nxt = (col_up == 4'h0);
            end
            else if (op_hi6 == nclea_pkg::PAT_TOGGLE_DOWN)
            begin
              acc_nxt = ram_rdata;
              ram_we = 1'b1;
              ptr_nxt.row = row_toggled;
              ptr_nxt.col = col_down;
              skip_nxt = (col_down == 4'hF);
            end
            else if (rom_data == nclea_pkg::OP_SUM)
            begin
              // carry flag untouched
              acc_nxt = sum_plain[3:0];
              skip_nxt = sum_plain[4];
            end
            else if (rom_data == nclea_pkg::OP_SUM_CARRY)
            begin
              // carry only ever set here and in sum_carry_then_skip, no skip
              acc_nxt = sum_carry[3:0];
              carry_nxt = carry_r | sum_carry[4];
            end
            else if (rom_data == nclea_pkg::OP_SUM_CARRY_SKIP)
            begin
              acc_nxt = sum_carry[3:0];
              carry_nxt = carry_r | sum_carry[4];
              skip_nxt = sum_carry[4];
            end
            else if (rom_data == nclea_pkg::OP_BCD_SUM)
            begin
              acc_nxt = acc_r + nclea_pkg::BCD_SUM_ADD;
            end
            else if (rom_data == nclea_pkg::OP_BCD_DIFF)
            begin
              acc_nxt = acc_r + nclea_pkg::BCD_DIFF_ADD;
            end
            else
            begin
              // opcodes outside this group pass as one-byte no-ops
              acc_nxt = acc_r;
            end
          end
        end
        nclea_pkg::ST_OPERAND:
        begin
          // top bit of operand byte is zero, low seven bits form the pointer
          pc_nxt = pc_r + 11'h001;
          ptr_nxt = rom_data[6:0];
          state_nxt = nclea_pkg::ST_FETCH;
        end
        nclea_pkg::ST_SKIP_OPERAND:
        begin
          // second byte of a skipped two-byte instruction
          pc_nxt = pc_r + 11'h001;
          state_nxt = nclea_pkg::ST_FETCH;
        end
        default:
        begin
          state_nxt = nclea_pkg::ST_FETCH;
        end
      endcase
    end
  end

  // accumulator, pointer and flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_r <= 4'h0;
      ptr_r <= '0;
      carry_r <= 1'b0;
      skip_r <= 1'b0;
      chain_r <= 1'b0;
    end
    else
    begin
      acc_r <= acc_nxt;
      ptr_r <= ptr_nxt;
      carry_r <= carry_nxt;
      skip_r <= skip_nxt;
      chain_r <= chain_nxt;
    end
  end

  // program address and sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_r <= 11'h000;
      state_r <= nclea_pkg::ST_FETCH;
    end
    else
    begin
      pc_r <= pc_nxt;
      state_r <= state_nxt;
    end
  end

  // data ram write, contents are not cleared by reset
  always_ff @(posedge pclk)
  begin
    if (ram_we)
    begin
      ram_mem[ptr_r.row][ptr_r.col] <= ram_wdata;
    end
  end

  // apb: zero wait states, error on unmapped offsets
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & ~pwrite;
  assign addr_hit = (paddr == nclea_pkg::OFS_CTRL) ||
                    (paddr == nclea_pkg::OFS_STATE) ||
                    (paddr == nclea_pkg::OFS_PC);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;
  assign prdata = prdata_r;

  // control register, run gates execution
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_r <= nclea_pkg::CTRL_RUN_RST;
    end
    else if (apb_wr && paddr == nclea_pkg::OFS_CTRL)
    begin
      run_r <= pwdata[nclea_pkg::CTRL_RUN_BIT];
    end
  end

  // read data captured in the setup cycle, valid through the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h0000_0000;
    end
    else if (apb_rd && !penable)
    begin
      prdata_r <= 32'h0000_0000;
      unique case (paddr)
        nclea_pkg::OFS_CTRL:
        begin
          prdata_r[nclea_pkg::CTRL_RUN_BIT] <= run_r;
        end
        nclea_pkg::OFS_STATE:
        begin
          prdata_r[nclea_pkg::ST_ACC_LSB +: 4] <= acc_r;
          prdata_r[nclea_pkg::ST_COL_LSB +: 4] <= ptr_r.col;
          prdata_r[nclea_pkg::ST_ROW_LSB +: 3] <= ptr_r.row;
          prdata_r[nclea_pkg::ST_CARRY_BIT] <= carry_r;
          prdata_r[nclea_pkg::ST_SKIP_BIT] <= skip_r;
          prdata_r[nclea_pkg::ST_CHAIN_BIT] <= chain_r;
        end
        nclea_pkg::OFS_PC:
        begin
          prdata_r[10:0] <= pc_r;
        end
        default:
        begin
          prdata_r <= 32'h0000_0000;
        end
      endcase
    end
  end

endmodule // nclea_core

// ### tb/nclea_properties.sv
// nclea_properties: port-level checks for the nibble core
// assumes it is bound into nclea_core; one clock, async active-low reset
`timescale 1ns/100ps
module nclea_properties
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [nclea_pkg::PC_W-1:0] rom_addr,
  input wire logic [7:0] rom_data
);
  logic run_r; // mirror of the run bit
  logic acc_w; // access phase
  logic rd_w; // read access phase
  logic map_w; // offset is a register
  assign acc_w = psel && penable;
  assign rd_w = acc_w && !pwrite;
  assign map_w = paddr == nclea_pkg::OFS_CTRL || paddr == nclea_pkg::OFS_STATE || paddr == nclea_pkg::OFS_PC;
  // follow completed writes to the control word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_r <= 1'b0;
    else if (acc_w && pwrite && pready && paddr == nclea_pkg::OFS_CTRL)
      run_r <= pwdata[nclea_pkg::CTRL_RUN_BIT];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  pready_high_a: assert property (pready)
    else $error("pready low");
  err_unmapped_a: assert property (acc_w && !map_w |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  err_mapped_a: assert property (acc_w && map_w |-> !pslverr)
    else $error("error on a mapped offset");
  err_idle_a: assert property (!acc_w |-> !pslverr)
    else $error("error outside access phase");
  pc_step_a: assert property (run_r |=> rom_addr == $past(rom_addr) + 11'h1)
    else $error("program address did not step by one");
  pc_hold_a: assert property (!run_r |=> $stable(rom_addr))
    else $error("program address moved while stopped");
  ctrl_read_a: assert property (rd_w && paddr == nclea_pkg::OFS_CTRL |-> prdata == {31'h0, run_r})
    else $error("control readback wrong");
  pc_read_a: assert property (rd_w && paddr == nclea_pkg::OFS_PC |-> prdata == {21'h0, $past(rom_addr)})
    else $error("program address readback wrong");
  state_pad_a: assert property (rd_w && paddr == nclea_pkg::OFS_STATE |-> prdata[31:15] == 17'h0)
    else $error("state upper bits not zero");
endmodule // nclea_properties

// ### tb/nclea_rom_model.sv
// nclea_rom_model: program store answering the core's fetch address
// assumes the bench fills mem while the core is held stopped
`timescale 1ns/100ps
module nclea_rom_model
(
  input wire logic [nclea_pkg::PC_W-1:0] rom_addr,
  output logic [7:0] rom_data
);
  logic [7:0] mem [0:(1<<nclea_pkg::PC_W)-1]; // program bytes
  // combinational read in the same cycle
  assign rom_data = mem[rom_addr];
  // empty places hold a byte outside the group
  initial
  begin
    foreach (mem[i])
      mem[i] = 8'hFF;
  end
endmodule // nclea_rom_model

// ### tb/nclea_core_tb_top.sv
// nclea_core_tb_top: self-checking bench running short programs
// assumes nclea_pkg, the rom model and the checker are compiled first
`timescale 1ns/100ps
module nclea_core_tb_top;
  logic pclk; // 200 MHz
  logic presetn; // active-low reset
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [nclea_pkg::PC_W-1:0] rom_addr;
  logic [7:0] rom_data;
  logic [32:0] exp_q [$]; // notes: {pslverr, prdata}
  logic [7:0] prog [$]; // program under test
  logic [31:0] seed = 32'h1AF24EB9; // xorshift state
  logic [7:0] ops [3] = '{8'h08, 8'h19, 8'h09}; // add kinds
  int fail_count = 0;
  int total_checks = 0;
  nclea_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rom_addr(rom_addr), .rom_data(rom_data));
  nclea_rom_model u_rom (.rom_addr(rom_addr), .rom_data(rom_data));
  // free-running clock
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // xorshift step for the random operands
  function automatic logic [31:0] xorshift(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  task automatic print_verdict();
    // a note left unanswered is a missed read
    if (exp_q.size() != 0)
      fail_count++;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one apb transfer; reads leave a note for the watcher
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    if (!w)
      exp_q.push_back(e);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      fail_count++;
      print_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // reset, load prog, run past its end, stop, read the core state
  task automatic run_prog(input logic [32:0] e);
    int n;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < (1 << nclea_pkg::PC_W); i++)
      u_rom.mem[i] = 8'hFF;
    foreach (prog[i])
      u_rom.mem[i] = prog[i];
    apb(1'b1, nclea_pkg::OFS_CTRL, 32'h1, 33'h0);
    n = 0;
    // program address looked at on the falling edge, where it has settled
    while (int'(rom_addr) <= prog.size() && n < 500)
    begin
      @(negedge pclk);
      n++;
    end
    if (int'(rom_addr) <= prog.size())
    begin
      fail_count++;
      print_verdict();
    end
    apb(1'b1, nclea_pkg::OFS_CTRL, 32'h0, 33'h0);
    apb(1'b0, nclea_pkg::OFS_STATE, 32'h0, e);
  endtask
  // expected state after: ptr 0, [00]=b, acc=a, op, +6, add with carry
  function automatic logic [32:0] sum_exp(input logic [7:0] op, input logic [3:0] a, input logic [3:0] b);
    logic [4:0] s;
    logic [4:0] t;
    logic k;
    logic c;
    s = {1'b0, a} + {1'b0, b};
    k = s[4] && op != 8'h19;
    c = s[4] && op != 8'h08;
    t = {1'b0, s[3:0] + (k ? 4'h0 : 4'h6)} + {1'b0, b} + {4'h0, c};
    return {20'h0, c | t[4], 8'h0, t[3:0]};
  endfunction
  // watcher: each read answer against the oldest note
  always @(posedge pclk)
  begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      check("apb read", {pslverr, prdata}, exp_q.pop_front());
  end
  // main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, nclea_pkg::OFS_STATE, 32'h0, 33'h0);
    apb(1'b0, nclea_pkg::OFS_PC, 32'h0, 33'h0);
    apb(1'b1, nclea_pkg::OFS_STATE, 32'h7FFF, 33'h0);
    apb(1'b0, nclea_pkg::OFS_STATE, 32'h0, 33'h0);
    apb(1'b0, 8'h0C, 32'h0, {1'b1, 32'h0});
    apb(1'b1, nclea_pkg::OFS_CTRL, 32'h1, 33'h0);
    // unmapped write must not reach the control word
    apb(1'b1, 8'h0C, 32'h0, 33'h0);
    apb(1'b0, nclea_pkg::OFS_CTRL, 32'h0, 33'h1);
    // immediate string, store, load, add with skip, decimal fixes
    prog = '{8'h93, 8'h95, 8'h02, 8'h9D, 8'h08, 8'h97, 8'h38, 8'h08, 8'h0A, 8'h06};
    run_prog(33'h6);
    // full pointer, swaps with column step and skips of one and two bytes
    prog = '{8'h15, 8'h5F, 8'h9A, 8'h02, 8'h91, 8'h28, 8'h3C, 8'h9E, 8'h02, 8'h2C, 8'h15, 8'h3F, 8'h38, 8'h07};
    run_prog(33'h05AA);
    // row toggles with load and swaps
    prog = '{8'h15, 8'h7E, 8'h12, 8'h02, 8'h3A, 8'h02, 8'h95, 8'h29, 8'h02, 8'h3D, 8'h02, 8'h3E, 8'h91,
      8'h02, 8'h2F, 8'h91};
    run_prog(33'h04FE);
    // zero-row pointer and random add kinds
    for (int i = 0; i < 6; i++)
    begin
      seed = xorshift(seed);
      prog = '{8'h80, {4'h9, seed[7:4]}, 8'h02, {4'h9, seed[3:0]}, ops[i%3], 8'h06, 8'h19};
      run_prog(sum_exp(ops[i%3], seed[3:0], seed[7:4]));
    end
    // let the watcher take the last answer before the verdict
    @(negedge pclk);
    print_verdict();
  end
endmodule // nclea_core_tb_top
bind nclea_core nclea_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rom_addr(rom_addr), .rom_data(rom_data));
